// ### core/fcs_command_sequencer.sv
// Command state machine of a multi-partition flash device
`timescale 1ns/10ps
module fcs_command_sequencer #(
    parameter int NUM_PART = fcs_pkg::NUM_PART,
    parameter int BUF_WORDS = fcs_pkg::BUF_WORDS,
    parameter int PART_W = (NUM_PART > 1) ? $clog2(NUM_PART) : 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cmdValid,
    input wire logic [15:0] cmdData,
    input wire logic [PART_W-1:0] cmdPart,
    output fcs_pkg::fcs_state_t seqState,
    output logic [2*NUM_PART-1:0] readMode,
    output logic opActive,
    output logic [PART_W-1:0] activePart,
    output logic programSuspended,
    output logic eraseSuspended,
    output logic errSequence,
    output logic errLock
);
    localparam int CW = $clog2(BUF_WORDS) + 1;
    typedef struct packed {
        fcs_pkg::fcs_state_t state;
        logic [CW-1:0] remain;
        logic [PART_W-1:0] actPart;
        logic [PART_W-1:0] ersPart;
        logic [NUM_PART-1:0][1:0] mode;
        logic seqErr;
        logic lockErr;
    } fcs_seq_t;
    fcs_seq_t seq_ff;
    fcs_seq_t nxt_seq;
    logic [7:0] cmdCode;
    logic opStart;
    logic [fcs_pkg::TIMER_W-1:0] opLen;
    logic opDone;
    logic setSeq;
    logic setLock;
    // States in which a write is a command rather than data
    function automatic logic isCmdState(input fcs_pkg::fcs_state_t s);
        return s inside {fcs_pkg::READY, fcs_pkg::PGM_BUSY,
            fcs_pkg::PGM_SUSP, fcs_pkg::BUF_BUSY, fcs_pkg::BUF_SUSP,
            fcs_pkg::ERS_BUSY, fcs_pkg::ERS_SUSP, fcs_pkg::ES_PGM_BUSY,
            fcs_pkg::ES_PGM_SUSP, fcs_pkg::ES_BUF_BUSY,
            fcs_pkg::ES_BUF_SUSP, fcs_pkg::OTP_BUSY, fcs_pkg::FBW_BUSY};
    endfunction
    function automatic logic isLockConfirm(input logic [7:0] c);
        return c inside {fcs_pkg::CMD_LOCK, fcs_pkg::CMD_CONFIRM,
            fcs_pkg::CMD_LOCKDOWN, fcs_pkg::CMD_CFG_SET};
    endfunction
    assign cmdCode = cmdData[7:0];
    // Status view of the registered state
    assign seqState = seq_ff.state;
    assign readMode = seq_ff.mode;
    assign activePart = seq_ff.actPart;
    assign errSequence = seq_ff.seqErr;
    assign errLock = seq_ff.lockErr;
    assign opActive = seq_ff.state inside {fcs_pkg::PGM_BUSY,
        fcs_pkg::BUF_BUSY, fcs_pkg::ERS_BUSY, fcs_pkg::ES_PGM_BUSY,
        fcs_pkg::ES_BUF_BUSY, fcs_pkg::OTP_BUSY, fcs_pkg::FBW_BUSY};
    assign programSuspended = seq_ff.state inside {fcs_pkg::PGM_SUSP,
        fcs_pkg::BUF_SUSP, fcs_pkg::ES_PGM_SUSP, fcs_pkg::ES_BUF_SUSP};
    assign eraseSuspended = seq_ff.state inside {fcs_pkg::ERS_SUSP,
        fcs_pkg::ES_PGM_SETUP, fcs_pkg::ES_PGM_BUSY,
        fcs_pkg::ES_PGM_SUSP, fcs_pkg::ES_BUF_SETUP,
        fcs_pkg::ES_BUF_LOAD1, fcs_pkg::ES_BUF_LOAD2,
        fcs_pkg::ES_BUF_CONFIRM, fcs_pkg::ES_BUF_BUSY,
        fcs_pkg::ES_BUF_SUSP, fcs_pkg::ES_LOCK_SETUP};
    // One shared timer is why only one operation can run at once
    fcs_op_timer #(
        .LEN_W(fcs_pkg::TIMER_W)
    ) uTimer (
        .core_clk(core_clk),
        .reset(reset),
        .start(opStart),
        .len(opLen),
        .hold(programSuspended || seq_ff.state == fcs_pkg::ERS_SUSP),
        .done(opDone)
    );
    // Next-state decode; read mode is never consulted here
    always_comb begin
        nxt_seq = seq_ff;
        opStart = 1'b0;
        opLen = fcs_pkg::PROG_CYC;
        setSeq = 1'b0;
        setLock = 1'b0;
        if (cmdValid && isCmdState(seq_ff.state)) begin
            case (cmdCode)
                fcs_pkg::CMD_READ_ARRAY:
                    nxt_seq.mode[cmdPart] = fcs_pkg::MODE_ARRAY;
                fcs_pkg::CMD_READ_ID:
                    nxt_seq.mode[cmdPart] = fcs_pkg::MODE_IDENT;
                fcs_pkg::CMD_QUERY:
                    nxt_seq.mode[cmdPart] = fcs_pkg::MODE_QUERY;
                fcs_pkg::CMD_READ_STATUS:
                    nxt_seq.mode[cmdPart] = fcs_pkg::MODE_STATUS;
                default: ;
            endcase
        end
        unique case (seq_ff.state)
            fcs_pkg::READY: if (cmdValid) begin
                nxt_seq.actPart = cmdPart;
                case (cmdCode)
                    fcs_pkg::CMD_PROG_A, fcs_pkg::CMD_PROG_B:
                        nxt_seq.state = fcs_pkg::PGM_SETUP;
                    fcs_pkg::CMD_BUF_SETUP: nxt_seq.state = fcs_pkg::BUF_SETUP;
                    fcs_pkg::CMD_ERASE_SETUP: begin
                        nxt_seq.state = fcs_pkg::ERS_SETUP;
                        nxt_seq.ersPart = cmdPart;
                    end
                    fcs_pkg::CMD_FBW_SETUP: nxt_seq.state = fcs_pkg::FBW_SETUP;
                    fcs_pkg::CMD_LOCK_SETUP:
                        nxt_seq.state = fcs_pkg::LOCK_SETUP;
                    fcs_pkg::CMD_OTP_SETUP: nxt_seq.state = fcs_pkg::OTP_SETUP;
                    default: nxt_seq.actPart = seq_ff.actPart;
                endcase
            end
            fcs_pkg::LOCK_SETUP, fcs_pkg::ES_LOCK_SETUP: if (cmdValid) begin
                nxt_seq.state = (seq_ff.state == fcs_pkg::LOCK_SETUP) ?
                    fcs_pkg::READY : fcs_pkg::ERS_SUSP;
                setLock = !isLockConfirm(cmdCode);
            end
            fcs_pkg::OTP_SETUP: if (cmdValid) begin
                nxt_seq.state = fcs_pkg::OTP_BUSY;
                opStart = 1'b1;
                opLen = fcs_pkg::OTP_CYC;
            end
            fcs_pkg::PGM_SETUP, fcs_pkg::ES_PGM_SETUP: if (cmdValid) begin
                nxt_seq.state = (seq_ff.state == fcs_pkg::PGM_SETUP) ?
                    fcs_pkg::PGM_BUSY : fcs_pkg::ES_PGM_BUSY;
                opStart = 1'b1;
            end
            fcs_pkg::BUF_SETUP, fcs_pkg::ES_BUF_SETUP: if (cmdValid) begin
                // Count field holds words minus one
                nxt_seq.remain = CW'(cmdData[CW-2:0]) + CW'(1);
                nxt_seq.state = (seq_ff.state == fcs_pkg::BUF_SETUP) ?
                    fcs_pkg::BUF_LOAD1 : fcs_pkg::ES_BUF_LOAD1;
            end
            fcs_pkg::BUF_LOAD1, fcs_pkg::BUF_LOAD2: if (cmdValid) begin
                nxt_seq.remain = seq_ff.remain - CW'(1);
                nxt_seq.state = (seq_ff.remain == CW'(1)) ?
                    fcs_pkg::BUF_CONFIRM : fcs_pkg::BUF_LOAD2;
            end
            fcs_pkg::ES_BUF_LOAD1, fcs_pkg::ES_BUF_LOAD2: if (cmdValid) begin
                nxt_seq.remain = seq_ff.remain - CW'(1);
                nxt_seq.state = (seq_ff.remain == CW'(1)) ?
                    fcs_pkg::ES_BUF_CONFIRM : fcs_pkg::ES_BUF_LOAD2;
            end
            fcs_pkg::BUF_CONFIRM, fcs_pkg::ES_BUF_CONFIRM,
            fcs_pkg::ERS_SETUP, fcs_pkg::FBW_SETUP: if (cmdValid) begin
                opStart = (cmdCode == fcs_pkg::CMD_CONFIRM);
                setSeq = !opStart;
                unique case (seq_ff.state)
                    fcs_pkg::BUF_CONFIRM: nxt_seq.state = opStart ?
                        fcs_pkg::BUF_BUSY : fcs_pkg::READY;
                    fcs_pkg::ES_BUF_CONFIRM: begin
                        nxt_seq.state = opStart ?
                            fcs_pkg::ES_BUF_BUSY : fcs_pkg::ERS_SUSP;
                        nxt_seq.actPart = opStart ?
                            seq_ff.actPart : seq_ff.ersPart;
                    end
                    fcs_pkg::ERS_SETUP: begin
                        nxt_seq.state = opStart ?
                            fcs_pkg::ERS_BUSY : fcs_pkg::READY;
                        opLen = fcs_pkg::ERASE_CYC;
                    end
                    fcs_pkg::FBW_SETUP: begin
                        nxt_seq.state = opStart ?
                            fcs_pkg::FBW_BUSY : fcs_pkg::READY;
                        opLen = fcs_pkg::FBW_CYC;
                    end
                endcase
            end
            // Completion beats a suspend arriving in the same cycle
            fcs_pkg::PGM_BUSY, fcs_pkg::BUF_BUSY, fcs_pkg::ERS_BUSY:
                if (opDone) begin
                nxt_seq.state = fcs_pkg::READY;
            end else if (cmdValid && cmdCode == fcs_pkg::CMD_SUSPEND) begin
                nxt_seq.state = (seq_ff.state == fcs_pkg::PGM_BUSY) ?
                    fcs_pkg::PGM_SUSP : (seq_ff.state == fcs_pkg::BUF_BUSY) ?
                    fcs_pkg::BUF_SUSP : fcs_pkg::ERS_SUSP;
            end
            fcs_pkg::ES_PGM_BUSY, fcs_pkg::ES_BUF_BUSY: if (opDone) begin
                nxt_seq.state = fcs_pkg::ERS_SUSP;
                nxt_seq.actPart = seq_ff.ersPart;
            end else if (cmdValid && cmdCode == fcs_pkg::CMD_SUSPEND) begin
                nxt_seq.state = (seq_ff.state == fcs_pkg::ES_PGM_BUSY) ?
                    fcs_pkg::ES_PGM_SUSP : fcs_pkg::ES_BUF_SUSP;
            end
            fcs_pkg::OTP_BUSY, fcs_pkg::FBW_BUSY: if (opDone) begin
                nxt_seq.state = fcs_pkg::READY;
            end
            // Suspended writes resume on confirm only
            fcs_pkg::PGM_SUSP, fcs_pkg::BUF_SUSP, fcs_pkg::ES_PGM_SUSP,
            fcs_pkg::ES_BUF_SUSP:
                if (cmdValid && cmdCode == fcs_pkg::CMD_CONFIRM) begin
                unique case (seq_ff.state)
                    fcs_pkg::PGM_SUSP: nxt_seq.state = fcs_pkg::PGM_BUSY;
                    fcs_pkg::BUF_SUSP: nxt_seq.state = fcs_pkg::BUF_BUSY;
                    fcs_pkg::ES_PGM_SUSP:
                        nxt_seq.state = fcs_pkg::ES_PGM_BUSY;
                    fcs_pkg::ES_BUF_SUSP:
                        nxt_seq.state = fcs_pkg::ES_BUF_BUSY;
                endcase
            end
            fcs_pkg::ERS_SUSP: if (cmdValid) begin
                case (cmdCode)
                    fcs_pkg::CMD_PROG_A, fcs_pkg::CMD_PROG_B: begin
                        nxt_seq.state = fcs_pkg::ES_PGM_SETUP;
                        nxt_seq.actPart = cmdPart;
                    end
                    fcs_pkg::CMD_BUF_SETUP: begin
                        nxt_seq.state = fcs_pkg::ES_BUF_SETUP;
                        nxt_seq.actPart = cmdPart;
                    end
                    fcs_pkg::CMD_LOCK_SETUP:
                        nxt_seq.state = fcs_pkg::ES_LOCK_SETUP;
                    // Nested work may reuse the timer, so erase restarts
                    fcs_pkg::CMD_CONFIRM: begin
                        nxt_seq.state = fcs_pkg::ERS_BUSY;
                        opStart = 1'b1;
                        opLen = fcs_pkg::ERASE_CYC;
                    end
                    default: ;
                endcase
            end
            default: nxt_seq.state = fcs_pkg::READY;
        endcase
        // Flags: a same-cycle set wins over the clear
        if (cmdValid && isCmdState(seq_ff.state) &&
            cmdCode == fcs_pkg::CMD_CLEAR_STATUS) begin
            nxt_seq.seqErr = 1'b0;
            nxt_seq.lockErr = 1'b0;
        end
        nxt_seq.seqErr = nxt_seq.seqErr || setSeq;
        nxt_seq.lockErr = nxt_seq.lockErr || setLock;
    end
    // Reset returns to ready with clean flags and array reads
    always_ff @(posedge core_clk) begin
        if (reset) begin
            seq_ff <= '0;
            seq_ff.state <= fcs_pkg::READY;
            seq_ff.mode <= {NUM_PART{fcs_pkg::MODE_ARRAY}};
        end else begin
            seq_ff <= nxt_seq;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence sLoading;
        seq_ff.state inside {fcs_pkg::BUF_LOAD1, fcs_pkg::BUF_LOAD2} &&
        cmdValid;
    endsequence
    chk_single_active: assert property (opActive && $past(opActive) &&
        seqState == $past(seqState) |-> $stable(activePart))
        else $error("active partition changed mid operation");
    chk_mode_hold: assert property (!cmdValid |=> $stable(readMode))
        else $error("read mode changed without a command");
    chk_status_ready: assert property (seqState == fcs_pkg::READY &&
        cmdValid && cmdCode == fcs_pkg::CMD_READ_STATUS
        |=> seqState == fcs_pkg::READY)
        else $error("read command moved the sequencer");
    chk_lock_error: assert property (seqState == fcs_pkg::LOCK_SETUP &&
        cmdValid && !isLockConfirm(cmdCode)
        |=> seqState == fcs_pkg::READY && errLock)
        else $error("bad lock confirm not flagged");
    chk_load_done: assert property (sLoading ##0 seq_ff.remain == CW'(1)
        |=> seqState == fcs_pkg::BUF_CONFIRM)
        else $error("buffer load did not reach confirm");
    chk_load_more: assert property (sLoading ##0 seq_ff.remain > CW'(1) |=>
        seqState == fcs_pkg::BUF_LOAD2 ##0 !$stable(seq_ff.remain))
        else $error("buffer load left early");
    chk_es_buf_err: assert property (seqState == fcs_pkg::ES_BUF_CONFIRM
        && cmdValid && cmdCode != fcs_pkg::CMD_CONFIRM
        |=> seqState == fcs_pkg::ERS_SUSP && errSequence)
        else $error("nested buffer error left erase suspend");
    chk_es_pgm_hold: assert property (seqState == fcs_pkg::ES_PGM_SUSP &&
        !(cmdValid && cmdCode == fcs_pkg::CMD_CONFIRM)
        |=> seqState == fcs_pkg::ES_PGM_SUSP)
        else $error("nested program left suspend");
    chk_clear_flags: assert property (seqState == fcs_pkg::READY &&
        cmdValid && cmdCode == fcs_pkg::CMD_CLEAR_STATUS
        |=> !errSequence && !errLock && $stable(readMode))
        else $error("clear status misbehaved");
    chk_erase_setup: assert property (seqState == fcs_pkg::ERS_SETUP &&
        cmdValid && cmdCode != fcs_pkg::CMD_CONFIRM
        |=> seqState == fcs_pkg::READY ##1 errSequence)
        else $error("wrong erase confirm not flagged");
endmodule

// ### core/fcs_op_timer.sv
// Duration counter standing in for the internal operation sequencer
`timescale 1ns/10ps
module fcs_op_timer #(
    parameter int LEN_W = fcs_pkg::TIMER_W
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [LEN_W-1:0] len,
    input wire logic hold,
    output logic done
);
    typedef struct packed {
        logic [LEN_W-1:0] count;
    } fcs_tmr_t;

    fcs_tmr_t tmr_ff;
    fcs_tmr_t nxt_tmr;

    // Last count fires once; a hold freezes it for suspend
    assign done = (tmr_ff.count == LEN_W'(1)) && !hold && !start;

    // Reload on start, otherwise count down while not held
    always_comb begin
        nxt_tmr = tmr_ff;
        if (start) begin
            nxt_tmr.count = len;
        end else if (!hold && tmr_ff.count != '0) begin
            nxt_tmr.count = tmr_ff.count - LEN_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tmr_ff <= '0;
        end else begin
            tmr_ff <= nxt_tmr;
        end
    end
endmodule

// ### core/fcs_pkg.sv
// Shared constants and types of the flash command sequencer
package fcs_pkg;
    // Array geometry defaults
    localparam int NUM_PART = 8;
    localparam int BUF_WORDS = 32;

    // Internal operation times and their cycle counts at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 1000;
    localparam int ERASE_TIME_NS = 10000;
    localparam int OTP_TIME_NS = 2000;
    localparam int FBW_TIME_NS = 4000;
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] PROG_CYC =
        TIMER_W'(PROG_TIME_NS / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] ERASE_CYC =
        TIMER_W'(ERASE_TIME_NS / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] OTP_CYC =
        TIMER_W'(OTP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] FBW_CYC =
        TIMER_W'(FBW_TIME_NS / CLK_PERIOD_NS);

    // Command codes
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_PROG_A = 8'h10;
    localparam logic [7:0] CMD_PROG_B = 8'h40;
    localparam logic [7:0] CMD_BUF_SETUP = 8'hE8;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_FBW_SETUP = 8'h80;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
    localparam logic [7:0] CMD_LOCK = 8'h01;
    localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
    localparam logic [7:0] CMD_CFG_SET = 8'h03;

    // Per-partition read modes
    localparam logic [1:0] MODE_ARRAY = 2'h0;
    localparam logic [1:0] MODE_IDENT = 2'h1;
    localparam logic [1:0] MODE_QUERY = 2'h2;
    localparam logic [1:0] MODE_STATUS = 2'h3;

    // Sequencer states, Gray steps in declaration order
    typedef enum logic [4:0] {
        READY = 5'h00, PGM_SETUP = 5'h01, PGM_BUSY = 5'h03,
        PGM_SUSP = 5'h02, BUF_SETUP = 5'h06, BUF_LOAD1 = 5'h07,
        BUF_LOAD2 = 5'h05, BUF_CONFIRM = 5'h04, BUF_BUSY = 5'h0C,
        BUF_SUSP = 5'h0D, ERS_SETUP = 5'h0F, ERS_BUSY = 5'h0E,
        ERS_SUSP = 5'h0A, ES_PGM_SETUP = 5'h0B, ES_PGM_BUSY = 5'h09,
        ES_PGM_SUSP = 5'h08, ES_BUF_SETUP = 5'h18, ES_BUF_LOAD1 = 5'h19,
        ES_BUF_LOAD2 = 5'h1B, ES_BUF_CONFIRM = 5'h1A,
        ES_BUF_BUSY = 5'h1E, ES_BUF_SUSP = 5'h1F, ES_LOCK_SETUP = 5'h1D,
        LOCK_SETUP = 5'h1C, OTP_SETUP = 5'h14, OTP_BUSY = 5'h15,
        FBW_SETUP = 5'h17, FBW_BUSY = 5'h16
    } fcs_state_t;
endpackage

// ### dv/fcs_host_model.sv
// Host model that issues command writes to the sequencer
`timescale 1ns/10ps
module fcs_host_model #(
    parameter int PART_W = 3
) (
    input wire logic core_clk,
    output logic cmdValid,
    output logic [15:0] cmdData,
    output logic [PART_W-1:0] cmdPart
);
    // Idle bus level at time zero
    initial begin
        cmdValid = 1'b0;
        cmdData = 16'h0000;
        cmdPart = '0;
    end

    // One write, driven at the falling edge and taken at the next rising
    task automatic wr(input logic [15:0] d, input int p);
        @(negedge core_clk);
        cmdValid = 1'b1;
        cmdData = d;
        cmdPart = PART_W'(p);
        @(negedge core_clk);
        cmdValid = 1'b0;
        // Inverted leftovers, so a stale bus never passes for a command
        cmdData = ~d;
        cmdPart = ~cmdPart;
    endtask

    // Count word is words minus one, then exactly that many data words
    task automatic buf_load(input int n, input int p);
        wr(16'(n - 1), p);
        for (int i = 0; i < n; i++) begin
            wr(16'h1230 + 16'(i), p);
        end
    endtask
endmodule

// ### dv/tb.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cmdValid;
    logic [15:0] cmdData;
    logic [2:0] cmdPart;
    fcs_pkg::fcs_state_t seqState;
    logic [15:0] readMode;
    logic [2:0] activePart;
    logic opActive, programSuspended, eraseSuspended, errSequence, errLock;
    int errors = 0;
    int n_compared = 0;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    fcs_command_sequencer uut (.core_clk(core_clk), .reset(reset),
        .cmdValid(cmdValid), .cmdData(cmdData), .cmdPart(cmdPart),
        .seqState(seqState), .readMode(readMode), .opActive(opActive),
        .activePart(activePart), .programSuspended(programSuspended),
        .eraseSuspended(eraseSuspended), .errSequence(errSequence),
        .errLock(errLock));

    fcs_host_model host (.core_clk(core_clk), .cmdValid(cmdValid),
        .cmdData(cmdData), .cmdPart(cmdPart));

    task automatic report_and_stop();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_st(input fcs_pkg::fcs_state_t exp);
        n_compared++;
        if (seqState !== exp) begin
            errors++;
            $display("ERROR seqState expected %h seen %h", exp, seqState);
        end
    endtask

    task automatic chk_mode(input int p, input logic [1:0] m);
        chk("readMode", 16'(m), 16'(readMode[2*p +: 2]));
    endtask

    // Bounded wait for a state; returns the cycles spent
    task automatic wait_st(input fcs_pkg::fcs_state_t s, input int max,
                           output int n);
        n = 0;
        while (seqState !== s && n < max) begin
            @(negedge core_clk);
            n++;
        end
        chk_st(s);
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
    endtask

    task automatic t_reset();
        chk_st(fcs_pkg::READY);
        chk("readMode", 16'h0000, readMode);
        chk("flags", 16'h0000, 16'({opActive, programSuspended,
            eraseSuspended, errSequence, errLock, activePart}));
    endtask

    // Read array and every setup code except OTP from ready, fresh reset before each
    task automatic t_dispatch();
        logic [7:0] c[7] = '{8'hFF, 8'h10, 8'h40, 8'hE8, 8'h20, 8'h80,
            8'h60};
        fcs_pkg::fcs_state_t s[7] = '{fcs_pkg::READY, fcs_pkg::PGM_SETUP,
            fcs_pkg::PGM_SETUP, fcs_pkg::BUF_SETUP, fcs_pkg::ERS_SETUP,
            fcs_pkg::FBW_SETUP, fcs_pkg::LOCK_SETUP};
        for (int i = 0; i < 7; i++) begin
            do_reset();
            host.wr(16'(c[i]), 1);
            chk_st(s[i]);
        end
    endtask

    task automatic t_word_prog();
        int n;
        do_reset();
        host.wr(16'h0040, 6);
        chk("activePart", 16'h0006, 16'(activePart));
        host.wr(16'h1234, 6);
        chk_st(fcs_pkg::PGM_BUSY);
        chk("opActive", 16'h0001, 16'(opActive));
        wait_st(fcs_pkg::READY, 300, n);
        chk("prog time", fcs_pkg::PROG_CYC, 16'(n));
    endtask

    task automatic t_lock();
        logic [7:0] ok[4] = '{8'h01, 8'hD0, 8'h2F, 8'h03};
        do_reset();
        for (int i = 0; i < 4; i++) begin
            host.wr(16'h0060, 0);
            host.wr(16'(ok[i]), 0);
            chk_st(fcs_pkg::READY);
            chk("errLock", 16'h0000, 16'(errLock));
        end
        host.wr(16'h0060, 0);
        host.wr(16'h00FF, 0);
        chk_st(fcs_pkg::READY);
        chk("errLock", 16'h0001, 16'(errLock));
        host.wr(16'h0090, 3);
        host.wr(16'h0050, 0);
        chk("errLock", 16'h0000, 16'(errLock));
        chk_mode(3, fcs_pkg::MODE_IDENT);
        host.wr(16'h0060, 0);
        host.wr(16'h0070, 0);
        chk("errLock", 16'h0001, 16'(errLock));
        do_reset();
        chk("errLock", 16'h0000, 16'(errLock));
    endtask

    task automatic t_buffer();
        int n;
        do_reset();
        host.wr(16'h00E8, 4);
        host.wr(16'h0002, 4);
        host.wr(16'hA5A5, 4);
        host.wr(16'h5A5A, 4);
        chk("early confirm", 16'h0000,
            16'(seqState === fcs_pkg::BUF_CONFIRM));
        host.wr(16'h00D0, 4);
        chk_st(fcs_pkg::BUF_CONFIRM);
        host.wr(16'h00D0, 4);
        chk_st(fcs_pkg::BUF_BUSY);
        host.wr(16'h00B0, 4);
        chk_st(fcs_pkg::BUF_SUSP);
        chk("progSusp", 16'h0001, 16'(programSuspended));
        host.wr(16'h00D0, 4);
        chk_st(fcs_pkg::BUF_BUSY);
        wait_st(fcs_pkg::READY, 3000, n);
        host.wr(16'h0020, 4);
        host.wr(16'h00FF, 4);
        chk_st(fcs_pkg::READY);
        chk("errSequence", 16'h0001, 16'(errSequence));
    endtask

    // Erase with reads elsewhere, nested program and nested buffer
    task automatic t_erase_nested();
        int n;
        do_reset();
        host.wr(16'h0020, 2);
        host.wr(16'h00D0, 2);
        host.wr(16'h0070, 5);
        host.wr(16'h0090, 1);
        host.wr(16'h0098, 0);
        chk_mode(5, fcs_pkg::MODE_STATUS);
        chk_mode(1, fcs_pkg::MODE_IDENT);
        chk_mode(0, fcs_pkg::MODE_QUERY);
        chk_st(fcs_pkg::ERS_BUSY);
        host.wr(16'h00B0, 5);
        chk_st(fcs_pkg::ERS_SUSP);
        host.wr(16'h0040, 3);
        host.wr(16'h1111, 3);
        chk_st(fcs_pkg::ES_PGM_BUSY);
        chk("activePart", 16'h0003, 16'(activePart));
        host.wr(16'h00B0, 3);
        host.wr(16'h0020, 3);
        host.wr(16'h00FF, 3);
        host.wr(16'h00E8, 3);
        chk_st(fcs_pkg::ES_PGM_SUSP);
        chk("suspends", 16'h0003,
            16'({programSuspended, eraseSuspended}));
        host.wr(16'h00D0, 3);
        chk_st(fcs_pkg::ES_PGM_BUSY);
        wait_st(fcs_pkg::ERS_SUSP, 300, n);
        chk("activePart", 16'h0002, 16'(activePart));
        host.wr(16'h00E8, 3);
        host.buf_load(1, 3);
        chk_st(fcs_pkg::ES_BUF_CONFIRM);
        host.wr(16'h00FF, 3);
        chk_st(fcs_pkg::ERS_SUSP);
        chk("errSequence", 16'h0001, 16'(errSequence));
        host.wr(16'h0050, 0);
        chk("errSequence", 16'h0000, 16'(errSequence));
        chk_mode(5, fcs_pkg::MODE_STATUS);
        host.wr(16'h00D0, 2);
        chk_st(fcs_pkg::ERS_BUSY);
        wait_st(fcs_pkg::READY, 1100, n);
    endtask

    // Status read in ready, OTP, factory, suspends, nested lock and buffer
    task automatic t_more_ops();
        int n;
        do_reset();
        host.wr(16'h0070, 7);
        chk_st(fcs_pkg::READY);
        chk_mode(7, fcs_pkg::MODE_STATUS);
        host.wr(16'h00C0, 7);
        host.wr(16'h4321, 7);
        chk_st(fcs_pkg::OTP_BUSY);
        chk("activePart", 16'h0007, 16'(activePart));
        wait_st(fcs_pkg::READY, 300, n);
        chk("otp time", fcs_pkg::OTP_CYC, 16'(n));
        host.wr(16'h0080, 6);
        host.wr(16'h00D0, 6);
        host.wr(16'h00B0, 6);
        chk_st(fcs_pkg::FBW_BUSY);
        wait_st(fcs_pkg::READY, 500, n);
        chk("fbw time", fcs_pkg::FBW_CYC - 16'h0002, 16'(n));
        host.wr(16'h0040, 0);
        host.wr(16'h5555, 0);
        host.wr(16'h00B0, 0);
        host.wr(16'h0090, 0);
        chk_st(fcs_pkg::PGM_SUSP);
        chk_mode(0, fcs_pkg::MODE_IDENT);
        host.wr(16'h00D0, 0);
        wait_st(fcs_pkg::READY, 300, n);
        host.wr(16'h0020, 1);
        host.wr(16'h00D0, 1);
        host.wr(16'h00B0, 1);
        host.wr(16'h0060, 1);
        host.wr(16'h00FF, 1);
        chk_st(fcs_pkg::ERS_SUSP);
        chk("errLock", 16'h0001, 16'(errLock));
        host.wr(16'h00E8, 4);
        host.buf_load(2, 4);
        host.wr(16'h00D0, 4);
        host.wr(16'h00B0, 4);
        chk_st(fcs_pkg::ES_BUF_SUSP);
        host.wr(16'h00D0, 4);
        wait_st(fcs_pkg::ERS_SUSP, 300, n);
        chk("activePart", 16'h0001, 16'(activePart));
        do_reset();
        t_reset();
    endtask

    initial begin
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        t_reset();
        t_dispatch();
        t_word_prog();
        t_lock();
        t_buffer();
        t_erase_nested();
        t_more_ops();
        report_and_stop();
    end

    // Tests need under 10000 cycles; a hang is cut well beyond that
    initial begin
        repeat (50000) @(posedge core_clk);
        errors++;
        report_and_stop();
    end
endmodule
